// >>> logic/iprg_arbiter.v
`include "iprg_defs.vh"

// Picks the pending, enabled source with the highest code; lower index wins ties
module iprg_arbiter #(
    parameter NSRC = 4
) (
    // Requests and codes
    input  wire [NSRC-1:0]   i_req,
    input  wire [NSRC*3-1:0] i_codes,
    // Result
    output reg               o_valid,
    output reg  [1:0]        o_index,
    output reg  [2:0]        o_level
);
    integer k;

    always @* begin
        o_valid = 1'b0;
        o_index = 2'h0;
        o_level = `IPRG_CODE_OFF;
        // Scan from the last source down so the lowest index keeps a tie
        for (k = NSRC - 1; k >= 0; k = k - 1) begin
            if (i_req[k] && i_codes[k*3 +: 3] != `IPRG_CODE_OFF &&
                    i_codes[k*3 +: 3] >= o_level) begin
                o_valid = 1'b1;
                o_index = k[1:0];
                o_level = i_codes[k*3 +: 3];
            end
        end
    end
endmodule

// >>> logic/iprg_defs.vh
`ifndef IPRG_DEFS_VH
`define IPRG_DEFS_VH

// Register byte offsets on the APB bus
`define IPRG_OFF_LEVELS   12'h000
`define IPRG_OFF_PENDING  12'h004
`define IPRG_OFF_WINNER   12'h008

// Priority field positions (low bit of each 3-bit field)
`define IPRG_POS_TIMER    12
`define IPRG_POS_COMPARE  8
`define IPRG_POS_CAPTURE  4
`define IPRG_POS_EXTIRQ   0

// Implemented bits of the priority register
`define IPRG_LEVELS_MASK  16'h7777
// Reset value: every field at level 4
`define IPRG_LEVELS_RST   16'h4444

// Code that disables a source, and the top level
`define IPRG_CODE_OFF     3'h0
`define IPRG_CODE_TOP     3'h7

`endif

// >>> logic/iprg_top.v
`include "iprg_defs.vh"

module iprg_top (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_srst,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    input  wire [3:0]  i_pstrb,
    output wire        o_pready,
    output reg  [31:0] o_prdata,
    output wire        o_pslverr,
    // Source requests: 0 timer, 1 compare, 2 capture, 3 external irq
    input  wire [3:0]  i_src_req,
    // Arbitration result to the core
    output reg         o_irq_valid,
    output reg  [1:0]  o_irq_index,
    output reg  [2:0]  o_irq_level,
    output reg  [11:0] o_priority_codes
);
    // Slave phase: a cycle with penable high counts only after a setup cycle
    localparam [0:0]  ST_IDLE     = 1'b0;
    localparam [0:0]  ST_SETUP    = 1'b1;

    // Sources and field width; the source order is also the tie order
    localparam        NSRC        = 4;
    localparam        CODE_W      = 3;
    localparam [15:0] LEVELS_RST  = `IPRG_LEVELS_RST;
    localparam [15:0] LEVELS_MASK = `IPRG_LEVELS_MASK;

    // Bus phase tracking
    reg  [0:0]             phase_reg;
    reg  [0:0]             phase_next;
    wire                   setup;
    wire                   access;
    wire                   setup_rd;
    wire                   wr_en;
    // Address decode
    wire                   sel_levels;
    wire                   sel_pending;
    wire                   sel_winner;
    wire                   addr_ok;
    // Priority fields, one code per source
    reg  [NSRC*CODE_W-1:0] codes_reg;
    wire [NSRC*CODE_W-1:0] codes_next;
    wire [NSRC*CODE_W-1:0] codes_rst;
    wire [15:0]            levels_word;
    // Arbitration
    wire                   arb_valid;
    wire [1:0]             arb_index;
    wire [2:0]             arb_level;
    // Read path
    wire [31:0]            levels_rd;
    wire [31:0]            pending_rd;
    wire [31:0]            winner_rd;
    reg  [31:0]            rd_next;

    function integer field_pos;
        input integer idx;
        begin
            case (idx)
                0:       field_pos = `IPRG_POS_TIMER;
                1:       field_pos = `IPRG_POS_COMPARE;
                2:       field_pos = `IPRG_POS_CAPTURE;
                default: field_pos = `IPRG_POS_EXTIRQ;
            endcase
        end
    endfunction

    // Bus phase
    assign setup    = i_psel & ~i_penable;
    assign access   = i_psel & i_penable & (phase_reg == ST_SETUP);
    assign setup_rd = setup & ~i_pwrite;

    always @* begin
        phase_next = ST_IDLE;
        case (phase_reg)
            ST_IDLE: begin
                if (setup) begin
                    phase_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // Zero-wait slave: the access cycle always closes the transfer
                if (setup) begin
                    phase_next = ST_SETUP;
                end
            end
            default: begin
                phase_next = ST_IDLE;
            end
        endcase
    end

    always @(posedge i_clk) begin
        if (i_srst) begin
            phase_reg <= ST_IDLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Zero-wait slave: every access completes in its first access cycle
    assign o_pready    = 1'b1;
    assign sel_levels  = (i_paddr == `IPRG_OFF_LEVELS);
    assign sel_pending = (i_paddr == `IPRG_OFF_PENDING);
    assign sel_winner  = (i_paddr == `IPRG_OFF_WINNER);
    assign addr_ok     = sel_levels | sel_pending | sel_winner;
    assign o_pslverr   = access & ~addr_ok;
    // Pending and winner words are read-only; writes there are dropped quietly
    assign wr_en       = access & i_pwrite & sel_levels;

    // One field per source; each field sits wholly inside one byte lane
    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : g_field
            localparam integer POS  = field_pos(g);
            localparam integer LANE = POS / 8;
            wire               lane_wr;

            assign lane_wr = wr_en & i_pstrb[LANE];
            assign codes_rst[g*CODE_W +: CODE_W]  = LEVELS_RST[POS +: CODE_W];
            assign codes_next[g*CODE_W +: CODE_W] = lane_wr ? i_pwdata[POS +: CODE_W] :
                                                    codes_reg[g*CODE_W +: CODE_W];
            assign levels_word[POS +: CODE_W]     = codes_reg[g*CODE_W +: CODE_W];
            // The bit above each field is not built and reads zero
            assign levels_word[POS + CODE_W]      = 1'b0;
        end
    endgenerate

    always @(posedge i_clk) begin
        if (i_srst) begin
            codes_reg <= codes_rst;
        end else begin
            codes_reg <= codes_next;
        end
    end

    iprg_arbiter #(
        .NSRC (NSRC)
    ) u_arb (
        .i_req   (i_src_req),
        .i_codes (codes_reg),
        .o_valid (arb_valid),
        .o_index (arb_index),
        .o_level (arb_level)
    );

    // Registered so the core sees a clean result one cycle after the request
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_irq_valid      <= 1'b0;
            o_irq_index      <= 2'h0;
            o_irq_level      <= 3'h0;
            o_priority_codes <= 12'h000;
        end else begin
            o_irq_valid      <= arb_valid;
            o_irq_index      <= arb_index;
            o_irq_level      <= arb_level;
            o_priority_codes <= codes_reg;
        end
    end

    assign levels_rd  = {16'h0000, levels_word & LEVELS_MASK};
    assign pending_rd = {28'h0000000, i_src_req};
    assign winner_rd  = {26'h0000000, o_irq_valid, o_irq_index, o_irq_level};

    always @* begin
        rd_next = 32'h00000000;
        if (sel_levels) begin
            rd_next = levels_rd;
        end else if (sel_pending) begin
            rd_next = pending_rd;
        end else if (sel_winner) begin
            rd_next = winner_rd;
        end
    end

    // Read data is captured in the setup cycle, valid through the access cycle
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_prdata <= 32'h00000000;
        end else if (setup_rd) begin
            o_prdata <= rd_next;
        end
    end
endmodule

// >>> verification/iprg_core_model.sv
module iprg_core_model (
    input wire logic       i_clk,
    input wire logic [3:0] i_set,
    output logic [3:0]     o_req
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sources hold their request as a level, one cycle behind the command
    always @(posedge i_clk) o_req <= i_set;
endmodule

// >>> verification/iprg_top_asserts.sv
module iprg_checker (
    input wire logic        i_clk, i_srst, i_psel, i_penable, i_pwrite, o_irq_valid,
    input wire logic [1:0]  o_irq_index,
    input wire logic [2:0]  o_irq_level,
    input wire logic [3:0]  i_pstrb, i_src_req,
    input wire logic [11:0] i_paddr, o_priority_codes,
    input wire logic [31:0] i_pwdata, o_prdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire        wr = i_psel & i_penable & i_pwrite & ~|i_paddr;
    wire [11:0] c  = o_priority_codes;
    a_timer_code: assert property (wr & i_pstrb[1] |=> ##1 c[2:0] == $past(i_pwdata[14:12], 2))
        else $error("bad timer code");
    a_compare_code: assert property (wr & i_pstrb[1] |=> ##1 c[5:3] == $past(i_pwdata[10:8], 2))
        else $error("bad compare code");
    a_low_codes: assert property (wr & i_pstrb[0] |=> ##1 c[11:6] == {$past(i_pwdata[2:0], 2),
        $past(i_pwdata[6:4], 2)}) else $error("bad low codes");
    a_level_code: assert property (o_irq_valid |-> o_irq_level == c[3*o_irq_index +: 3])
        else $error("level differs from code");
    a_off_source: assert property (o_irq_valid |-> o_irq_level != 3'h0 &&
        (($past(i_src_req) >> o_irq_index) & 4'h1) == 4'h1) else $error("idle source won");
    a_unimpl_zero: assert property (i_psel & i_penable & ~i_pwrite & ~|i_paddr |->
        (o_prdata & 32'hFFFF8888) == 32'h0) else $error("unused bits set");
    a_timer_first: assert property ($past(i_src_req[0]) && c[2:0] != 3'h0 &&
        c[2:0] >= o_irq_level |-> o_irq_valid && o_irq_index == 2'h0) else $error("wrong winner");
    cover property (o_irq_valid && o_irq_level == 3'h7);
    cover property (o_irq_valid && o_irq_index == 2'h3);
    cover property (wr & ~i_pstrb[1]);
endmodule

bind iprg_top iprg_checker u_chk (.*);

// >>> verification/iprg_top_test.sv
`define CHK(nm, e, s) begin comparisons++; if ((s) !== (e)) begin fails++; \
    $display("FAIL %s exp %h got %h", nm, e, s); end end
module iprg_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_srst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq_valid;
    logic        err;
    logic [1:0]  o_irq_index;
    logic [2:0]  o_irq_level;
    logic [3:0]  i_pstrb, i_src_req, req_set;
    logic [11:0] i_paddr, o_priority_codes;
    logic [31:0] i_pwdata, o_prdata, rd;
    int          fails, comparisons;
    iprg_top uut (.*);
    iprg_core_model u_core (.i_clk(i_clk), .i_set(req_set), .o_req(i_src_req));
    initial begin i_clk = 0; forever #5 i_clk = ~i_clk; end
    task finish_test;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge i_clk);
        {i_psel, i_pwrite, i_paddr, i_pwdata, i_pstrb} <= {1'b1, w, a, d, s};
        @(posedge i_clk) i_penable <= 1;
        n = 0;
        do @(posedge i_clk); while (o_pready !== 1'b1 && ++n < 20);
        if (n == 20) begin fails++; finish_test; end
        rd = o_prdata;
        err = o_pslverr;
        {i_psel, i_penable} <= 0;
    endtask
    task req_chk(input logic [3:0] r, input logic [5:0] e);
        @(posedge i_clk) req_set <= r;
        repeat (3) @(posedge i_clk);
        #1 `CHK("winner", e, {o_irq_valid, o_irq_index, o_irq_level})
    endtask
    task t_reset;
        apb(0, 12'h000, 0, 0);
        `CHK("levels", 32'h4444, rd)
        `CHK("codes", 12'h924, o_priority_codes)
        `CHK("slverr", 1'b0, err)
    endtask
    task t_fields;
        apb(1, 12'h000, 32'hFFFFFFFF, 4'hF);
        apb(0, 12'h000, 0, 0);
        `CHK("levels", 32'h7777, rd)
        apb(1, 12'h000, 32'h1357, 4'hF);
        apb(1, 12'h000, 32'h7777, 4'h1);
        apb(0, 12'h000, 0, 0);
        `CHK("levels", 32'h1377, rd)
        `CHK("codes", 12'hFD9, o_priority_codes)
        apb(0, 12'h00C, 0, 0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("slverr", 1'b1, err)
    endtask
    task t_arb;
        apb(1, 12'h000, 32'h1357, 4'hF);
        req_chk(4'hF, 6'h3F);
        apb(0, 12'h008, 0, 0);
        `CHK("winner rd", 32'h3F, rd)
        req_chk(4'h7, 6'h35);
        apb(1, 12'h000, 32'h5550, 4'hF);
        req_chk(4'hF, 6'h25);
        apb(1, 12'h000, 32'h0001, 4'hF);
        req_chk(4'hF, 6'h39);
        apb(1, 12'h000, 32'h0000, 4'hF);
        req_chk(4'hF, 6'h00);
    endtask
    initial begin
        i_srst = 1'b1;
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_pstrb, req_set} = '0;
        repeat (10) @(posedge i_clk);
        i_srst <= 0;
        t_reset;
        t_fields;
        t_arb;
        finish_test;
    end
endmodule
